// *** bench/cnta_monitor.sv ***
// Port-level checker for the counter array top
`timescale 1ns/1ns
`include "cnta_consts.vh"
module cnta_monitor #(
    parameter NUM_MOD = 5
) (
    input wire               sys_clk,
    input wire               reset,
    input wire [7:0]         s_axi_awaddr,
    input wire               s_axi_awvalid,
    input wire               s_axi_awready,
    input wire               s_axi_wvalid,
    input wire               s_axi_wready,
    input wire [1:0]         s_axi_bresp,
    input wire               s_axi_bvalid,
    input wire               s_axi_bready,
    input wire               s_axi_arvalid,
    input wire               s_axi_arready,
    input wire [31:0]        s_axi_rdata,
    input wire [1:0]         s_axi_rresp,
    input wire               s_axi_rvalid,
    input wire               s_axi_rready,
    input wire [NUM_MOD-1:0] moduleIoPinOut,
    input wire [NUM_MOD-1:0] moduleIoPinOeN,
    input wire               irq_r,
    input wire               wdReset_r
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshakes: answers come on time and stand until taken
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response not two edges after the take");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed before bready");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one edge after the take");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed before rready");
    a_refused_zero: assert property (s_axi_rvalid && s_axi_rresp == `CNTA_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");
    ////////////////////////////////////////////////////////////////////////////////
    // Events: interrupt clears, pins move only when driven, watchdog pulses once
    a_irq_clears: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `CNTA_OFS_CLEAR
        |-> ##[1:4] !irq_r)
        else $error("interrupt still high after a clear");
    a_pin_owned: assert property (((moduleIoPinOut ^ $past(moduleIoPinOut)) & moduleIoPinOeN) == '0)
        else $error("pin output moved while not driven");
    a_wd_single: assert property (wdReset_r |=> !wdReset_r [*3])
        else $error("watchdog reset longer than one cycle");
    a_wd_quiet: assert property (wdReset_r |-> !s_axi_bvalid || s_axi_awready == $past(s_axi_awready))
        else $error("watchdog reset disturbed the bus side");
    c_wd: cover property (wdReset_r);
    c_irq: cover property ($rose(irq_r));
    c_refused: cover property (s_axi_rvalid && s_axi_rresp == `CNTA_RESP_SLVERR);
endmodule
bind cnta_top cnta_monitor #(.NUM_MOD(NUM_MOD)) mon (.sys_clk(sys_clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .moduleIoPinOut(moduleIoPinOut),
    .moduleIoPinOeN(moduleIoPinOeN), .irq_r(irq_r), .wdReset_r(wdReset_r));

// *** bench/cnta_pin_model.sv ***
// Far-side model of the module pins: pulled-up sources that yield to the device
`timescale 1ns/1ns
module cnta_pin_model #(
    parameter N = 5
) (
    input  wire [N-1:0] srcLevel,
    input  wire [N-1:0] pinOut,
    input  wire [N-1:0] pinOeN,
    output wire [N-1:0] pinLevel
);
    // Device wins where it drives; a released pin shows the source, which idles high
    assign pinLevel = (pinOut & ~pinOeN) | (srcLevel & pinOeN);
endmodule

// *** bench/cnta_top_test.sv ***
// Self-checking bench for the counter array top
`timescale 1ns/1ns
`include "cnta_consts.vh"
module cnta_top_test;
    localparam [7:0] CTL = `CNTA_OFS_CTRL, CNT = `CNTA_OFS_COUNT, STS = `CNTA_OFS_STATUS;
    localparam [7:0] CLR = `CNTA_OFS_CLEAR, IEN = `CNTA_OFS_IRQEN;
    reg         sys_clk, reset, awValid, wValid, bReady, arValid, rReady;
    reg  [7:0]  awAddr, arAddr;
    reg  [31:0] wData, rv;
    reg  [4:0]  srcLevel;
    reg  [1:0]  rr;
    wire        awReady, wReady, bValid, arReady, rValid, irq, wdRst;
    wire [1:0]  bResp, rResp;
    wire [31:0] rData;
    wire [4:0]  pinOut, pinOeN, pinLevel;
    integer     fails, compares, wdPulses;
    cnta_top uut (.sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .moduleIoPinIn(pinLevel),
        .moduleIoPinOut(pinOut), .moduleIoPinOeN(pinOeN), .irq_r(irq), .wdReset_r(wdRst));
    cnta_pin_model #(.N(5)) pins (.srcLevel(srcLevel), .pinOut(pinOut), .pinOeN(pinOeN), .pinLevel(pinLevel));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, watchdog-pulse tally and hang guard (tests need a few hundred cycles)
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
        if (wdRst === 1'b1) wdPulses <= wdPulses + 1;
    initial begin
        #400000;
        fails = fails + 1;
        stop_test;
    end
    // Compare one result, count it and report a mismatch
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("unexpected %0s: expected %h, seen %h", nm, e, g);
            end
        end
    endtask
    // Bus write: address and data offered together, each released when taken
    task wr(input [7:0] a, input [31:0] d);
        reg done;
        begin
            done = 1'b0;
            awAddr <= a;
            wData <= d;
            awValid <= 1'b1;
            wValid <= 1'b1;
            bReady <= 1'b1;
            while (!done) begin
                @(posedge sys_clk);
                if (awValid && awReady) awValid <= 1'b0;
                if (wValid && wReady) wValid <= 1'b0;
                if (bValid && bReady) begin
                    done = 1'b1;
                    rr = bResp;
                end
            end
        end
    endtask
    // Bus read: data and response taken at the edge where rvalid is seen
    task rd(input [7:0] a);
        reg done;
        begin
            done = 1'b0;
            arAddr <= a;
            arValid <= 1'b1;
            rReady <= 1'b1;
            while (!done) begin
                @(posedge sys_clk);
                if (arValid && arReady) arValid <= 1'b0;
                if (rValid && rReady) begin
                    done = 1'b1;
                    rv = rData;
                    rr = rResp;
                end
            end
        end
    endtask
    task rdChk(input [7:0] a, input [31:0] e);
        begin
            rd(a);
            chk("register", e, rv);
        end
    endtask
    // Pin source change, held six clocks so the synchroniser sees it once
    task pin(input integer i, input v);
        begin
            srcLevel[i] <= v;
            repeat (6) @(posedge sys_clk);
        end
    endtask
    task stop_test;
        begin
            $display("comparisons %0d, mismatches %0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; the counter is stopped whenever an exact value is expected
    initial begin
        {awValid, wValid, bReady, arValid, rReady} = 5'h00;
        {awAddr, arAddr, wData} = 48'h0;
        srcLevel = 5'h1F;
        {fails, compares, wdPulses} = 96'h0;
        reset = 1'b1;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rdChk(CTL, 32'h0);
        rdChk(STS, 32'h0);
        chk("pins", 32'h1F, pinLevel);
        chk("irq", 32'h0, irq);
        rd(8'h14);
        chk("resp", `CNTA_RESP_SLVERR, rr);
        wr(8'h14, 32'h0);
        chk("bresp", `CNTA_RESP_SLVERR, rr);
        $display("test reset done");
        // Rise-only capture (fall ignored, rise copies the count), then fall-only capture
        wr(8'h20, 32'h20);
        wr(CNT, 32'h00AA);
        pin(0, 1'b0);
        wr(CNT, 32'h1234);
        pin(0, 1'b1);
        rdChk(8'h24, 32'h34);
        rdChk(8'h28, 32'h12);
        rdChk(STS, 32'h01);
        chk("irq", 32'h0, irq);
        wr(IEN, 32'h01);
        repeat (2) @(posedge sys_clk);
        chk("irq", 32'h1, irq);
        wr(CLR, 32'h01);
        repeat (4) @(posedge sys_clk);
        rdChk(STS, 32'h0);
        chk("irq", 32'h0, irq);
        wr(8'h20, 32'h11);
        wr(CNT, 32'h5678);
        pin(0, 1'b0);
        rdChk(8'h24, 32'h78);
        wr(CLR, 32'h01);
        $display("test capture done");
        // Pulse width on module 1, duty reload only at low-byte wrap
        wr(8'h34, 32'h40);
        wr(8'h38, 32'h80);
        wr(8'h30, 32'h42);
        wr(CNT, 32'h003F);
        repeat (3) @(posedge sys_clk);
        chk("pwm pin", 32'h0, pinLevel[1]);
        chk("pwm oe", 32'h0, pinOeN[1]);
        wr(CNT, 32'h0040);
        repeat (3) @(posedge sys_clk);
        chk("pwm pin", 32'h1, pinLevel[1]);
        rdChk(8'h34, 32'h40);
        wr(CNT, 32'hFFFE);
        wr(CTL, 32'h1);
        repeat (4) @(posedge sys_clk);
        wr(CTL, 32'h0);
        rdChk(8'h34, 32'h80);
        $display("test pwm done");
        // Toggle output on module 2 with compare 0x0010
        wr(8'h44, 32'h10);
        wr(8'h48, 32'h00);
        wr(8'h40, 32'h4C);
        wr(CNT, 32'h000E);
        wr(CTL, 32'h1);
        repeat (4) @(posedge sys_clk);
        wr(CTL, 32'h0);
        chk("toggle pin", 32'h0, pinLevel[2]);
        rdChk(STS, 32'h24);
        $display("test toggle done");
        // Watchdog on module 4: one match, then a moved compare holds it off
        wr(8'h64, 32'h20);
        wr(8'h68, 32'h00);
        wr(8'h60, 32'h48);
        wr(CNT, 32'h001C);
        wr(CTL, 32'h3);
        repeat (4) @(posedge sys_clk);
        wr(CTL, 32'h2);
        chk("wd pulses", 32'h1, wdPulses);
        rdChk(8'h30, 32'h42);
        rdChk(STS, 32'h34);
        wr(CLR, 32'h10);
        wr(8'h68, 32'h01);
        wr(CNT, 32'h001C);
        wr(CTL, 32'h3);
        repeat (4) @(posedge sys_clk);
        wr(CTL, 32'h0);
        chk("wd pulses", 32'h1, wdPulses);
        rdChk(STS, 32'h24);
        $display("test watchdog done");
        stop_test;
    end
endmodule

// *** hdl/cnta_channel.v ***
// One compare/capture module of the counter array
`timescale 1ns/1ns
module cnta_channel (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire        cntNew,
    input  wire [15:0] count,
    input  wire [6:0]  mode,
    input  wire        swWrLow,
    input  wire        swWrHigh,
    input  wire [7:0]  swData,
    input  wire        pinIn,
    output reg  [7:0]  lowReg_r,
    output reg  [7:0]  highReg_r,
    output reg         eventPulse_r,
    output reg         matchPulse_r,
    output reg         pinOut_r,
    output reg         pinOeN_r
);
`include "cnta_consts.vh"

    reg  pinSync1_r;
    reg  pinSync2_r;
    reg  pinLast_r;
    wire comparator_en;
    wire pwmMode;
    wire riseSeen;
    wire fallSeen;
    wire capture;
    wire match;

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode and events
    assign comparator_en     = mode[`CNTA_MODE_COMPARATOR_EN];
    assign pwmMode  = comparator_en & mode[`CNTA_MODE_PWM];
    assign riseSeen = pinSync2_r & ~pinLast_r & mode[`CNTA_MODE_RISE];
    assign fallSeen = ~pinSync2_r & pinLast_r & mode[`CNTA_MODE_FALL];
    assign capture  = riseSeen | fallSeen;
    // Compare only once per counter step, so one match gives one event
    assign match    = cntNew & comparator_en & ~pwmMode & (count == {highReg_r, lowReg_r});

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser, reset to the idle level; first stage feeds only the second
    always @(posedge sys_clk) begin
        if (reset) begin
            pinSync1_r <= `CNTA_PIN_RST;
            pinSync2_r <= `CNTA_PIN_RST;
            pinLast_r  <= `CNTA_PIN_RST;
        end else begin
            pinSync1_r <= pinIn;
            pinSync2_r <= pinSync1_r;
            pinLast_r  <= pinSync2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Value registers: capture beats software, software beats duty reload
    always @(posedge sys_clk) begin
        if (reset) begin
            lowReg_r  <= `CNTA_BYTE_RST;
            highReg_r <= `CNTA_BYTE_RST;
        end else if (capture) begin
            lowReg_r  <= count[7:0];
            highReg_r <= count[15:8];
        end else begin
            if (swWrHigh) begin
                highReg_r <= swData;
            end
            if (swWrLow) begin
                lowReg_r <= swData;
            end else if (pwmMode && cntNew && count[7:0] == `CNTA_LOW_WRAP) begin
                lowReg_r <= highReg_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pin, event and match pulses
    always @(posedge sys_clk) begin
        if (reset) begin
            pinOut_r     <= `CNTA_PIN_RST;
            pinOeN_r     <= 1'b1;
            eventPulse_r <= 1'b0;
            matchPulse_r <= 1'b0;
        end else begin
            if (pwmMode) begin
                pinOut_r <= (count[7:0] >= lowReg_r);
            end else if (match && mode[`CNTA_MODE_TOG]) begin
                pinOut_r <= ~pinOut_r;
            end
            // Drive the pin only in an output mode; otherwise it serves capture
            pinOeN_r     <= ~(comparator_en & (mode[`CNTA_MODE_PWM] | mode[`CNTA_MODE_TOG]));
            eventPulse_r <= capture | (match & mode[`CNTA_MODE_MAT]);
            matchPulse_r <= match;
        end
    end

endmodule

// *** hdl/cnta_consts.vh ***
// Constants for the counter array: register map, field positions, reset values
`ifndef CNTA_CONSTS_VH
`define CNTA_CONSTS_VH

// Register byte offsets on the AXI4-Lite slave
`define CNTA_OFS_CTRL       8'h00
`define CNTA_OFS_COUNT      8'h04
`define CNTA_OFS_STATUS     8'h08
`define CNTA_OFS_CLEAR      8'h0C
`define CNTA_OFS_IRQEN      8'h10
`define CNTA_OFS_CHAN_BASE  8'h20
`define CNTA_OFS_CHAN_LAST  8'h6C
`define CNTA_CHAN_STRIDE_SH 4
`define CNTA_CHAN_SUB_MODE  2'h0
`define CNTA_CHAN_SUB_LOW   2'h1
`define CNTA_CHAN_SUB_HIGH  2'h2

// Control register fields
`define CNTA_CTRL_RUN       0
`define CNTA_CTRL_WDT_EN    1
`define CNTA_CTRL_RST       2'h0

// Mode register fields (bit 0 mirrors the interrupt enable bit)
`define CNTA_MODE_COMPARATOR_EN      6
`define CNTA_MODE_RISE      5
`define CNTA_MODE_FALL      4
`define CNTA_MODE_MAT       3
`define CNTA_MODE_TOG       2
`define CNTA_MODE_PWM       1
`define CNTA_MODE_IRQ       0
`define CNTA_MODE_RST       7'h00

// Status layout: bits 4..0 module flags, bit 5 counter overflow
`define CNTA_ST_OVF         5
`define CNTA_ST_RST         6'h00

// Misc values
`define CNTA_CNT_RST        16'h0000
`define CNTA_BYTE_RST       8'h00
`define CNTA_LOW_WRAP       8'h00
`define CNTA_CNT_MAX        16'hFFFF
`define CNTA_PIN_RST        1'b1
`define CNTA_RESP_OKAY      2'h0
`define CNTA_RESP_SLVERR    2'h2

`endif

// *** hdl/cnta_top.v ***
// Counter array top: shared counter, five modules, watchdog, AXI4-Lite registers
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
module cnta_top #(
    parameter NUM_MOD = 5,
    parameter WDT_MOD = 4,
    parameter DIV     = 1
) (
    input  wire                 sys_clk,
    input  wire                 reset,
    input  wire [7:0]           s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output reg                  s_axi_awready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output reg                  s_axi_wready,
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    input  wire [7:0]           s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output reg                  s_axi_arready,
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    input  wire [NUM_MOD-1:0]   moduleIoPinIn,
    output wire [NUM_MOD-1:0]   moduleIoPinOut,
    output wire [NUM_MOD-1:0]   moduleIoPinOeN,
    output reg                  irq_r,
    output reg                  wdReset_r
);
`include "cnta_consts.vh"

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    reg  [1:0]           ctrl_r;
    reg  [15:0]          count_r;
    reg  [15:0]          count_nxt;
    reg                  cntNew_r;
    reg  [7:0]           divCnt_r;
    reg  [6*NUM_MOD-1:0] modeFlat_r;
    reg  [NUM_MOD:0]     irqEn_r;
    reg  [NUM_MOD:0]     flags_r;
    reg  [NUM_MOD:0]     flags_nxt;
    reg  [7:0]           awAddr_r;
    reg  [31:0]          wData_r;
    reg  [3:0]           wStrb_r;
    reg                  awHeld_r;
    reg                  wHeld_r;
    reg  [31:0]          rdValue;
    reg                  rdHit;
    reg                  wrHit;
    reg  [NUM_MOD-1:0]   swWrLow;
    reg  [NUM_MOD-1:0]   swWrHigh;
    reg  [NUM_MOD:0]     clrBits;
    wire [8*NUM_MOD-1:0] lowAll;
    wire [8*NUM_MOD-1:0] highAll;
    wire [NUM_MOD-1:0]   eventAll;
    wire [NUM_MOD-1:0]   matchAll;
    wire                 awTake;
    wire                 wTake;
    wire                 doWrite;
    wire                 awHeld_nxt;
    wire                 wHeld_nxt;
    wire                 bvalid_nxt;
    wire                 arTake;
    wire                 rvalid_nxt;
    wire                 divTick;
    wire                 cntWrap;
    wire                 wrCount;
    wire [2:0]           wrChan;
    wire [1:0]           wrSub;
    wire                 wrChanOk;
    wire [2:0]           rdChan;
    wire [1:0]           rdSub;
    wire                 rdChanOk;
    wire [15:0]          wrMerged;

    ////////////////////////////////////////////////////////////////////////////
    // Decoders shared by read and write paths
    function chanHit;
        input [7:0] addr;
        begin
            chanHit = (addr >= `CNTA_OFS_CHAN_BASE) && (addr <= `CNTA_OFS_CHAN_LAST)
                      && (addr[3:2] != 2'h3) && (addr[1:0] == 2'h0);
        end
    endfunction

    function [2:0] chanIdx;
        input [7:0] addr;
        reg   [7:0] rel;
        begin
            rel     = addr - `CNTA_OFS_CHAN_BASE;
            chanIdx = rel[6:4];
        end
    endfunction

    // Byte-lane merge of 16-bit register contents with write data
    function [15:0] mergeLanes;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  strb;
        begin
            mergeLanes[7:0]  = strb[0] ? data[7:0]  : old[7:0];
            mergeLanes[15:8] = strb[1] ? data[15:8] : old[15:8];
        end
    endfunction

    assign wrChanOk = chanHit(awAddr_r);
    assign wrChan   = chanIdx(awAddr_r);
    assign wrSub    = awAddr_r[3:2];
    assign rdChanOk = chanHit(s_axi_araddr);
    assign rdChan   = chanIdx(s_axi_araddr);
    assign rdSub    = s_axi_araddr[3:2];
    assign wrMerged = mergeLanes(count_r, wData_r, wStrb_r);

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes: address and data taken in any order, answer after both
    assign awTake     = s_axi_awready & s_axi_awvalid;
    assign wTake      = s_axi_wready & s_axi_wvalid;
    assign doWrite    = awHeld_r & wHeld_r & ~s_axi_bvalid;
    assign awHeld_nxt = (awHeld_r | awTake) & ~doWrite;
    assign wHeld_nxt  = (wHeld_r | wTake) & ~doWrite;
    assign bvalid_nxt = doWrite | (s_axi_bvalid & ~s_axi_bready);
    assign arTake     = s_axi_arready & s_axi_arvalid;
    assign rvalid_nxt = arTake | (s_axi_rvalid & ~s_axi_rready);

    always @(posedge sys_clk) begin
        if (reset) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CNTA_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `CNTA_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            awHeld_r      <= 1'b0;
            wHeld_r       <= 1'b0;
            awAddr_r      <= 8'h00;
            wData_r       <= 32'h0000_0000;
            wStrb_r       <= 4'h0;
        end else begin
            awHeld_r      <= awHeld_nxt;
            wHeld_r       <= wHeld_nxt;
            s_axi_awready <= ~awHeld_nxt;
            s_axi_wready  <= ~wHeld_nxt;
            s_axi_bvalid  <= bvalid_nxt;
            s_axi_arready <= ~rvalid_nxt;
            s_axi_rvalid  <= rvalid_nxt;
            if (awTake) begin
                awAddr_r <= s_axi_awaddr;
            end
            if (wTake) begin
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                s_axi_bresp <= wrHit ? `CNTA_RESP_OKAY : `CNTA_RESP_SLVERR;
            end
            if (arTake) begin
                s_axi_rdata <= rdValue;
                s_axi_rresp <= rdHit ? `CNTA_RESP_OKAY : `CNTA_RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; unmapped addresses read zero with an error response
    always @* begin
        rdValue = 32'h0000_0000;
        rdHit   = 1'b1;
        if (rdChanOk) begin
            case (rdSub)
                `CNTA_CHAN_SUB_MODE: rdValue[6:0] = {modeFlat_r[6*rdChan +: 6], irqEn_r[rdChan]};
                `CNTA_CHAN_SUB_LOW:  rdValue[7:0] = lowAll[8*rdChan +: 8];
                `CNTA_CHAN_SUB_HIGH: rdValue[7:0] = highAll[8*rdChan +: 8];
                default:             rdHit = 1'b0;
            endcase
        end else begin
            case (s_axi_araddr)
                `CNTA_OFS_CTRL:   rdValue[1:0]       = ctrl_r;
                `CNTA_OFS_COUNT:  rdValue[15:0]      = count_r;
                `CNTA_OFS_STATUS: rdValue[NUM_MOD:0] = flags_r;
                `CNTA_OFS_CLEAR:  rdValue            = 32'h0000_0000;   // Write-only
                `CNTA_OFS_IRQEN:  rdValue[NUM_MOD:0] = irqEn_r;
                default:          rdHit = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write decode into strobes for the modules and the flag clear
    always @* begin
        wrHit    = wrChanOk;
        swWrLow  = {NUM_MOD{1'b0}};
        swWrHigh = {NUM_MOD{1'b0}};
        clrBits  = {(NUM_MOD+1){1'b0}};
        if (doWrite && wrChanOk && wStrb_r[0]) begin
            swWrLow[wrChan]  = (wrSub == `CNTA_CHAN_SUB_LOW);
            swWrHigh[wrChan] = (wrSub == `CNTA_CHAN_SUB_HIGH);
        end
        if (!wrChanOk) begin
            case (awAddr_r)
                `CNTA_OFS_CTRL, `CNTA_OFS_COUNT, `CNTA_OFS_IRQEN: wrHit = 1'b1;
                `CNTA_OFS_STATUS: wrHit = 1'b1;   // Read-only, write ignored
                `CNTA_OFS_CLEAR: begin
                    wrHit   = 1'b1;
                    clrBits = (doWrite && wStrb_r[0]) ? wData_r[NUM_MOD:0] : {(NUM_MOD+1){1'b0}};
                end
                default: wrHit = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control, enable and mode registers
    always @(posedge sys_clk) begin
        if (reset) begin
            ctrl_r     <= `CNTA_CTRL_RST;
            irqEn_r    <= `CNTA_ST_RST;
            modeFlat_r <= {NUM_MOD{6'h00}};
        end else if (doWrite && wStrb_r[0]) begin
            if (wrChanOk && wrSub == `CNTA_CHAN_SUB_MODE) begin
                modeFlat_r[6*wrChan +: 6] <= wData_r[6:1];
                irqEn_r[wrChan]           <= wData_r[`CNTA_MODE_IRQ];
            end else if (!wrChanOk && awAddr_r == `CNTA_OFS_CTRL) begin
                ctrl_r <= wData_r[1:0];
            end else if (!wrChanOk && awAddr_r == `CNTA_OFS_IRQEN) begin
                irqEn_r <= wData_r[NUM_MOD:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared counter with prescaler; software may load it, which shifts all modules
    assign divTick = ctrl_r[`CNTA_CTRL_RUN] && (divCnt_r == DIV[7:0] - 8'h01);
    assign wrCount = doWrite && !wrChanOk && (awAddr_r == `CNTA_OFS_COUNT);
    assign cntWrap = divTick && (count_r == `CNTA_CNT_MAX);

    always @* begin
        count_nxt = count_r;
        if (wrCount) begin
            count_nxt = wrMerged;
        end else if (divTick) begin
            count_nxt = count_r + 16'h0001;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            count_r  <= `CNTA_CNT_RST;
            divCnt_r <= 8'h00;
            cntNew_r <= 1'b0;
        end else begin
            count_r  <= count_nxt;
            cntNew_r <= wrCount | divTick;
            if (!ctrl_r[`CNTA_CTRL_RUN] || divTick) begin
                divCnt_r <= 8'h00;
            end else begin
                divCnt_r <= divCnt_r + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare/capture modules, all fed from the one counter
    genvar gi;
    generate
        for (gi = 0; gi < NUM_MOD; gi = gi + 1) begin : gMod
            cnta_channel uChan (
                .sys_clk      (sys_clk),
                .reset        (reset),
                .cntNew       (cntNew_r),
                .count        (count_r),
                .mode         ({modeFlat_r[6*gi +: 6], irqEn_r[gi]}),
                .swWrLow      (swWrLow[gi]),
                .swWrHigh     (swWrHigh[gi]),
                .swData       (wData_r[7:0]),
                .pinIn        (moduleIoPinIn[gi]),
                .lowReg_r     (lowAll[8*gi +: 8]),
                .highReg_r    (highAll[8*gi +: 8]),
                .eventPulse_r (eventAll[gi]),
                .matchPulse_r (matchAll[gi]),
                .pinOut_r     (moduleIoPinOut[gi]),
                .pinOeN_r     (moduleIoPinOeN[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags: a new event in the clear cycle survives
    always @* begin
        flags_nxt                 = flags_r & ~clrBits;
        flags_nxt[NUM_MOD-1:0]    = flags_nxt[NUM_MOD-1:0] | eventAll;
        flags_nxt[`CNTA_ST_OVF]   = flags_nxt[`CNTA_ST_OVF] | cntWrap;
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            flags_r <= `CNTA_ST_RST;
            irq_r   <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            irq_r   <= |(flags_r & irqEn_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog on one module only; its reset is a separate internal output,
    // never fed back to the reset input, so the external reset pin is untouched
    always @(posedge sys_clk) begin
        if (reset) begin
            wdReset_r <= 1'b0;
        end else begin
            wdReset_r <= ctrl_r[`CNTA_CTRL_WDT_EN] & matchAll[WDT_MOD];
        end
    end

endmodule
